// file: hw/pin_supervisor_consts.svh
// constants for the card pin supervisor
`ifndef PIN_SUPERVISOR_CONSTS_SVH
`define PIN_SUPERVISOR_CONSTS_SVH

// status byte bit positions
`define STAT_AUX0_BIT      3'h0
`define STAT_AUX1_BIT      3'h1
`define STAT_UNDERV_BIT    3'h2
`define STAT_OVERLOAD_BIT  3'h3
`define STAT_PRESENCE_BIT  3'h4
`define STAT_BYTE_RESET    8'h00

// synchroniser reset: pins idle high, supply monitor flags idle low
`define SYNC_RESET         6'h38

// presence filter default sample count
`define PRES_FILTER_DEF    16

// power-down step length, in ns, and cycles at 125 MHz (8 ns period)
`define PDOWN_STEP_NS      80
`define CLK_PERIOD_NS      8
`define PDOWN_STEP_CYC     ((`PDOWN_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: hw/pin_supervisor_pkg.sv
// types for the card pin supervisor
package pin_supervisor_pkg;

  // power sequencer states
  typedef enum logic [2:0] {
    PWR_OFF,
    PWR_STARTUP,
    PWR_ON,
    PWR_DOWN_CLK,
    PWR_DOWN_AUX,
    PWR_DOWN_SUPPLY
  } pwr_state_t;

  // host command fields
  typedef struct packed {
    logic supply_on;
    logic clk_slow_slope;
    logic presence_active_high;
    logic special_mode;
    logic sync_mode;
    logic aux0_drive;
    logic aux1_drive;
  } host_cmd_t;

  // analog supply monitor inputs
  typedef struct packed {
    logic supply_good;
    logic undervoltage;
    logic overload;
  } supply_mon_t;

  // open-drain pin triple
  typedef struct packed {
    logic in;
    logic out;
    logic oe;
  } od_pin_t;

endpackage

// file: hw/pin_supervisor.sv
// card-side pin supervision: supply faults, aux lines, card clock and presence
//
// Behaviour
// RULE_01 - undervoltage sets a status bit; converter untouched; host recovers.
// RULE_02 - overload switches converter off, runs power-down sequence, records fault.
// RULE_03 - first aux line is sync signal or id bit, returned as status bit 0.
// RULE_04 - second aux line is sync signal or id bit, returned as status bit 1.
// RULE_05 - aux lines open-drain only; grounded reads zero, open or high reads one.
// RULE_06 - sync mode aux read returns level last forced by the device.
// RULE_07 - card clock from clock selector; held low at start-up and supply off.
// RULE_08 - host picks fast or slow card clock slope; device applies it.
// RULE_09 - presence input weakly pulled high; switch to ground is active low.
// RULE_10 - presence input is digitally filtered against spikes.
// RULE_11 - host sets presence switch polarity; filtered level read by it.
// RULE_12 - normal mode: status bit 4 high when card inserted, any polarity.
// RULE_13 - special mode: status bit 4 mirrors raw presence input level.
// RULE_14 - host ignores status bits 7 to 5, which carry no meaning.
// RULE_15 - presence filter takes a level after N stable consecutive samples.
`timescale 1ns/1ps
`include "pin_supervisor_consts.svh"

module pin_supervisor #(
  parameter int unsigned FILTER_SAMPLES = `PRES_FILTER_DEF,
  parameter int unsigned PDOWN_CYCLES   = `PDOWN_STEP_CYC
) (
  // clock and reset
  input  wire logic                               ref_clk,
  input  wire logic                               rst_b,
  // host command and status
  input  wire pin_supervisor_pkg::host_cmd_t      host_cmd,
  input  wire logic                               supply_fault_clear,
  output logic [7:0]                              status_byte,
  // analog supply monitor and converter control
  input  wire pin_supervisor_pkg::supply_mon_t    supply_mon,
  output logic                                    converter_enable,
  output logic                                    card_supply_undervoltage,
  // clock selector and card clock pin
  input  wire logic                               clk_sel_out,
  output logic                                    card_clock_out,
  output logic                                    card_clock_pulldown,
  output logic                                    card_clock_slow_slope,
  // card presence pin
  input  wire logic                               card_presence_in,
  output logic                                    card_presence_pullup_en,
  output logic                                    card_present,
  // auxiliary open-drain lines
  input  wire logic                               aux_line_id_bit0_in,
  output logic                                    aux_line_id_bit0_out,
  output logic                                    aux_line_id_bit0_oe,
  input  wire logic                               aux_line_id_bit1_in,
  output logic                                    aux_line_id_bit1_out,
  output logic                                    aux_line_id_bit1_oe
);
  import pin_supervisor_pkg::*;

  localparam int unsigned FCW = $clog2(FILTER_SAMPLES + 1);
  localparam int unsigned PCW = $clog2(PDOWN_CYCLES + 1);

  if (FILTER_SAMPLES < 2) begin : gen_bad_filter
    $error("FILTER_SAMPLES must be at least 2");
  end
  if (PDOWN_CYCLES < 1) begin : gen_bad_pdown
    $error("PDOWN_CYCLES must be at least 1");
  end

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // pins and analog comparators arrive asynchronously
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [5:0] sync_raw;
  logic       pres_s;
  logic       aux0_s;
  logic       aux1_s;
  logic       uv_s;
  logic       ovl_s;
  logic       good_s;

  assign sync_raw = {card_presence_in, aux_line_id_bit0_in, aux_line_id_bit1_in,
                     supply_mon.undervoltage, supply_mon.overload, supply_mon.supply_good};

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      // monitor flags start idle, so no false overload is seen after reset
      sync1_q <= `SYNC_RESET;
      sync2_q <= `SYNC_RESET;
    end else begin
      sync1_q <= sync_raw;
      sync2_q <= sync1_q;
    end
  end

  assign {pres_s, aux0_s, aux1_s, uv_s, ovl_s, good_s} = sync2_q;

  // ------------------------------------------------------------
  // power sequencer
  // ------------------------------------------------------------
  pwr_state_t       pwr_q;
  pwr_state_t       pwr_d;
  logic [PCW-1:0]   step_q;
  logic [PCW-1:0]   step_d;
  logic             ovl_flag_q;
  logic             ovl_flag_d;
  logic             uv_flag_q;
  logic             uv_flag_d;

  always_comb begin
    pwr_d      = pwr_q;
    step_d     = step_q;
    ovl_flag_d = ovl_flag_q;
    uv_flag_d  = uv_flag_q;
    // undervoltage only reports; the converter keeps running  (see RULE_01)
    if (supply_fault_clear) begin
      uv_flag_d  = 1'b0;
      ovl_flag_d = 1'b0;
    end
    if (uv_s) begin
      uv_flag_d = 1'b1;
    end
    unique case (pwr_q)
      PWR_OFF: begin
        if (host_cmd.supply_on && !ovl_flag_q) begin
          pwr_d = PWR_STARTUP;
        end
      end
      PWR_STARTUP: begin
        if (ovl_s) begin
          pwr_d  = PWR_DOWN_CLK;
          step_d = '0;
        end else if (good_s) begin
          pwr_d = PWR_ON;
        end else if (!host_cmd.supply_on) begin
          pwr_d = PWR_OFF;
        end
      end
      PWR_ON: begin
        if (ovl_s || !host_cmd.supply_on) begin
          pwr_d  = PWR_DOWN_CLK;
          step_d = '0;
        end
      end
      PWR_DOWN_CLK, PWR_DOWN_AUX, PWR_DOWN_SUPPLY: begin
        // each step of the deactivation holds a fixed time  (see RULE_02)
        if (step_q == PCW'(PDOWN_CYCLES - 1)) begin
          step_d = '0;
          unique case (pwr_q)
            PWR_DOWN_CLK: pwr_d = PWR_DOWN_AUX;
            PWR_DOWN_AUX: pwr_d = PWR_DOWN_SUPPLY;
            default:      pwr_d = PWR_OFF;
          endcase
        end else begin
          step_d = step_q + PCW'(1);
        end
      end
    endcase
    // overload latches; set wins over clear  (see RULE_02)
    if (ovl_s && pwr_q != PWR_OFF) begin
      ovl_flag_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pwr_q      <= PWR_OFF;
      step_q     <= '0;
      ovl_flag_q <= 1'b0;
      uv_flag_q  <= 1'b0;
    end else begin
      pwr_q      <= pwr_d;
      step_q     <= step_d;
      ovl_flag_q <= ovl_flag_d;
      uv_flag_q  <= uv_flag_d;
    end
  end

  // ------------------------------------------------------------
  // presence filter
  // ------------------------------------------------------------
  logic [FCW-1:0] fcnt_q;
  logic [FCW-1:0] fcnt_d;
  logic           pres_filt_q;
  logic           pres_filt_d;

  always_comb begin
    fcnt_d      = fcnt_q;
    pres_filt_d = pres_filt_q;
    // a new level is taken only after it stays stable  (see RULE_10) (see RULE_15)
    if (pres_s == pres_filt_q) begin
      fcnt_d = '0;
    end else if (fcnt_q == FCW'(FILTER_SAMPLES - 1)) begin
      fcnt_d      = '0;
      pres_filt_d = pres_s;
    end else begin
      fcnt_d = fcnt_q + FCW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      fcnt_q      <= '0;
      pres_filt_q <= 1'b1;
    end else begin
      fcnt_q      <= fcnt_d;
      pres_filt_q <= pres_filt_d;
    end
  end

  // ------------------------------------------------------------
  // pin outputs and status
  // ------------------------------------------------------------
  logic supply_active;
  logic clk_run;
  logic aux_run;
  logic aux0_rd;
  logic aux1_rd;
  logic [7:0] status_d;
  logic [7:0] status_q;
  logic       clk_q;
  logic       slope_q;

  assign supply_active = (pwr_q == PWR_ON) || (pwr_q == PWR_DOWN_CLK)
                      || (pwr_q == PWR_DOWN_AUX);
  assign clk_run       = (pwr_q == PWR_ON);
  assign aux_run       = (pwr_q == PWR_ON) || (pwr_q == PWR_DOWN_CLK);

  // converter stays on through undervoltage, off after overload  (see RULE_01) (see RULE_02)
  assign converter_enable         = supply_active || (pwr_q == PWR_STARTUP);
  assign card_supply_undervoltage = uv_flag_q;

  // card clock follows the selector only when supply is up  (see RULE_07)
  assign card_clock_out        = clk_q;
  assign card_clock_pulldown   = !clk_run;
  assign card_clock_slow_slope = slope_q;

  // weak pull-up always on, so an open switch reads high  (see RULE_09)
  assign card_presence_pullup_en = 1'b1;
  // polarity set by host; default active low  (see RULE_11)
  assign card_present = host_cmd.presence_active_high ? pres_filt_q : !pres_filt_q;

  // open-drain only: drive low or release, never drive high  (see RULE_05)
  assign aux_line_id_bit0_out = 1'b0;
  assign aux_line_id_bit1_out = 1'b0;
  assign aux_line_id_bit0_oe  = !aux_run || !host_cmd.aux0_drive;
  assign aux_line_id_bit1_oe  = !aux_run || !host_cmd.aux1_drive;

  // sync mode returns the forced level, not card data  (see RULE_06)
  assign aux0_rd = host_cmd.sync_mode ? (aux_run && host_cmd.aux0_drive) : aux0_s;
  assign aux1_rd = host_cmd.sync_mode ? (aux_run && host_cmd.aux1_drive) : aux1_s;

  always_comb begin
    status_d = `STAT_BYTE_RESET;
    status_d[`STAT_AUX0_BIT]     = aux0_rd;       // see RULE_03
    status_d[`STAT_AUX1_BIT]     = aux1_rd;       // see RULE_04
    status_d[`STAT_UNDERV_BIT]   = uv_flag_q;     // see RULE_01
    status_d[`STAT_OVERLOAD_BIT] = ovl_flag_q;    // see RULE_02
    // special mode mirrors the raw pin; normal mode reports insertion  (see RULE_12) (see RULE_13)
    status_d[`STAT_PRESENCE_BIT] = host_cmd.special_mode ? pres_s : card_present;
    // bits 7..5 stay zero and carry nothing
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      status_q <= `STAT_BYTE_RESET;
      clk_q    <= 1'b0;
      slope_q  <= 1'b0;
    end else begin
      status_q <= status_d;
      // clock gated through a flop; adds one cycle of latency to the selector
      clk_q    <= clk_run && clk_sel_out;    // see RULE_07
      slope_q  <= host_cmd.clk_slow_slope;   // see RULE_08
    end
  end

  assign status_byte = status_q;

endmodule

// file: test/pin_supervisor_checker.sv
// assertions on the card pin supervisor ports
`timescale 1ns/1ps
module pin_supervisor_checker
  import pin_supervisor_pkg::*;
#(
  parameter int unsigned FILTER_SAMPLES = 16,
  parameter int unsigned PDOWN_CYCLES   = 10
) (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_b,
  // watched ports
  input wire host_cmd_t  host_cmd,
  input wire logic [7:0] status_byte,
  input wire logic       converter_enable,
  input wire logic       card_supply_undervoltage,
  input wire logic       card_clock_out,
  input wire logic       card_clock_pulldown,
  input wire logic       card_clock_slow_slope,
  input wire logic       card_presence_in,
  input wire logic       card_presence_pullup_en,
  input wire logic       card_present,
  input wire logic       aux_line_id_bit0_out,
  input wire logic       aux_line_id_bit1_out
);
  // three power-down steps plus margin for sync and state latency
  localparam int PD_MAX = 3 * PDOWN_CYCLES + 8;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_fault_seen;
    $rose(status_byte[3]);
  endsequence
  sequence s_pdown;
    card_clock_pulldown ##[1:PD_MAX] !converter_enable;
  endsequence
  a_clock_low_off: assert property (!converter_enable |-> !card_clock_out)
    else $error("card clock high with supply off");
  a_clock_pull_low: assert property (card_clock_pulldown |=> !card_clock_out)
    else $error("card clock high while held low");
  a_slope_applied: assert property ($past(rst_b) |-> card_clock_slow_slope == $past(host_cmd.clk_slow_slope))
    else $error("clock slope not applied");
  a_aux0_open_drain: assert property (!aux_line_id_bit0_out)
    else $error("first aux line driven high");
  a_aux1_open_drain: assert property (!aux_line_id_bit1_out)
    else $error("second aux line driven high");
  a_underv_status: assert property ($rose(card_supply_undervoltage) |-> ##[0:2] status_byte[2])
    else $error("undervoltage not in status");
  a_overload_pdown: assert property (s_fault_seen |-> s_pdown)
    else $error("overload without power-down");
  a_pullup_on: assert property (card_presence_pullup_en)
    else $error("presence bias off");
  a_special_mirror: assert property ((host_cmd.special_mode && $stable(card_presence_in))[*5] |->
    status_byte[4] == card_presence_in)
    else $error("special mode presence bit wrong");
  a_normal_present: assert property ((!host_cmd.special_mode)[*2] |-> status_byte[4] == $past(card_present))
    else $error("normal mode presence bit wrong");
  c_fault: cover property (s_fault_seen);
endmodule

bind pin_supervisor pin_supervisor_checker #(.FILTER_SAMPLES(FILTER_SAMPLES), .PDOWN_CYCLES(PDOWN_CYCLES)) i_chk (
  .ref_clk, .rst_b, .host_cmd, .status_byte, .converter_enable, .card_supply_undervoltage,
  .card_clock_out, .card_clock_pulldown, .card_clock_slow_slope, .card_presence_in,
  .card_presence_pullup_en, .card_present, .aux_line_id_bit0_out, .aux_line_id_bit1_out);

// file: test/card_model.sv
// behavioural smart card at the connector
`timescale 1ns/1ps
module card_model (
  // card side pins
  input  wire logic       aux0_oe,
  input  wire logic       aux1_oe,
  input  wire logic       pullup_en,
  output logic            aux0_line,
  output logic            aux1_line,
  output logic            presence_pin,
  // scenario controls
  input  wire logic [1:0] card_gnd,
  input  wire logic       switch_closed
);
  // pull-ups to the card supply: a released line reads one
  assign aux0_line = !(aux0_oe || card_gnd[0]);
  assign aux1_line = !(aux1_oe || card_gnd[1]);
  // switch to ground against the weak bias
  assign presence_pin = switch_closed ? 1'b0 : pullup_en;
endmodule

// file: test/smart_card_pin_supervisor_bench.sv
// self-checking bench for the card pin supervisor
`timescale 1ns/1ps
module smart_card_pin_supervisor_bench;
  import pin_supervisor_pkg::*;
  localparam int FS = 4;
  localparam int PD = 2;
  logic        ref_clk = 0;
  logic        rst_b = 0;
  host_cmd_t   host_cmd = '0;
  supply_mon_t supply_mon = '0;
  logic        supply_fault_clear = 0;
  logic        clk_sel_out = 0;
  logic [1:0]  gnd = 2'h0;
  logic        sw = 0;
  logic [7:0]  status_byte;
  logic        converter_enable, card_supply_undervoltage, card_clock_out, card_clock_pulldown;
  logic        card_clock_slow_slope, card_presence_in, card_presence_pullup_en, card_present;
  logic        aux_line_id_bit0_in, aux_line_id_bit0_out, aux_line_id_bit0_oe;
  logic        aux_line_id_bit1_in, aux_line_id_bit1_out, aux_line_id_bit1_oe;
  logic [2:0]  watch;
  int          mismatches = 0;
  int          checks = 0;
  always #4 ref_clk = ~ref_clk;
  assign watch = {status_byte[3], converter_enable, card_clock_pulldown};
  pin_supervisor #(.FILTER_SAMPLES(FS), .PDOWN_CYCLES(PD)) i_dut (
    .ref_clk, .rst_b, .host_cmd, .supply_fault_clear, .status_byte, .supply_mon, .converter_enable,
    .card_supply_undervoltage, .clk_sel_out, .card_clock_out, .card_clock_pulldown,
    .card_clock_slow_slope, .card_presence_in, .card_presence_pullup_en, .card_present,
    .aux_line_id_bit0_in, .aux_line_id_bit0_out, .aux_line_id_bit0_oe,
    .aux_line_id_bit1_in, .aux_line_id_bit1_out, .aux_line_id_bit1_oe);
  card_model i_card (
    .aux0_oe(aux_line_id_bit0_oe), .aux1_oe(aux_line_id_bit1_oe), .pullup_en(card_presence_pullup_en),
    .aux0_line(aux_line_id_bit0_in), .aux1_line(aux_line_id_bit1_in), .presence_pin(card_presence_in),
    .card_gnd(gnd), .switch_closed(sw));
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // bounded poll on one watched bit; a hang ends the run
  task automatic wait_bit(int i, logic v);
    int n;
    n = 0;
    while (watch[i] !== v && n < 60) begin
      tick(1);
      n++;
    end
    if (watch[i] !== v) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  initial begin
    tick(5);
    chk("reset status", status_byte, 8'h00);
    chk("reset pins", {converter_enable, card_clock_out, card_clock_pulldown, aux_line_id_bit0_oe,
      aux_line_id_bit1_oe, card_presence_pullup_en}, 8'h0f);
    rst_b = 1;
    host_cmd = '{supply_on: 1, aux0_drive: 1, aux1_drive: 1, default: 0};
    supply_mon.supply_good = 1;
    wait_bit(0, 0);
    for (int k = 0; k < 4; k++) begin
      clk_sel_out = ~clk_sel_out;
      tick(1);
      chk("card clock", card_clock_out, clk_sel_out);
    end
    for (int v = 1; v >= 0; v--) begin
      host_cmd.clk_slow_slope = v[0];
      tick(1);
      chk("slope", card_clock_slow_slope, v[0]);
    end
    $display("test power and clock done");
    for (int g = 1; g <= 2; g++) begin
      gnd = g[1:0];
      tick(4);
      chk("aux status", status_byte[1:0], 2'(~g[1:0]));
    end
    host_cmd.sync_mode = 1;
    host_cmd.aux0_drive = 0;
    tick(4);
    chk("sync readback", status_byte[1:0], 2'h2);
    chk("aux enables", {aux_line_id_bit1_oe, aux_line_id_bit0_oe}, 2'h1);
    host_cmd.sync_mode = 0;
    host_cmd.aux0_drive = 1;
    gnd = 2'h0;
    $display("test aux lines done");
    sw = 1;
    tick(FS + 6);
    chk("present low", {card_present, status_byte[4]}, 2'h3);
    sw = 0;
    tick(FS - 2);
    sw = 1;
    // short glitch must never reach the presence output
    repeat (FS + 6) begin
      tick(1);
      chk("spike", card_present, 1'b1);
    end
    host_cmd.presence_active_high = 1;
    tick(3);
    chk("polarity", {card_present, status_byte[4]}, 2'h0);
    sw = 0;
    tick(FS + 6);
    chk("present high", {card_present, status_byte[4]}, 2'h3);
    host_cmd.presence_active_high = 0;
    host_cmd.special_mode = 1;
    for (int p = 0; p < 2; p++) begin
      sw = p[0];
      tick(6);
      chk("raw mirror", status_byte[4], !p[0]);
    end
    host_cmd.special_mode = 0;
    $display("test presence done");
    supply_mon.undervoltage = 1;
    tick(4);
    supply_mon.undervoltage = 0;
    tick(3);
    chk("undervoltage", {card_supply_undervoltage, status_byte[2], converter_enable, card_clock_pulldown},
      4'he);
    supply_fault_clear = 1;
    tick(1);
    supply_fault_clear = 0;
    tick(4);
    chk("uv clear", {card_supply_undervoltage, status_byte[2]}, 2'h0);
    $display("test undervoltage done");
    supply_mon.overload = 1;
    wait_bit(2, 1);
    chk("overload clock", card_clock_pulldown, 1'b1);
    supply_mon.overload = 0;
    wait_bit(1, 0);
    chk("powered down", {aux_line_id_bit0_oe, aux_line_id_bit1_oe, card_clock_out}, 3'h6);
    tick(8);
    chk("restart refused", {converter_enable, status_byte[3]}, 2'h1);
    supply_fault_clear = 1;
    tick(1);
    supply_fault_clear = 0;
    wait_bit(1, 1);
    $display("test overload done");
    report_and_stop();
  end
endmodule
